// file: rtl/biphase_ctl_regs.svh
`ifndef BIPHASE_CTL_REGS_SVH
`define BIPHASE_CTL_REGS_SVH

// Register addresses
`define ADDR_CONTROL 5'h00
`define ADDR_DEEMPH 5'h01
`define ADDR_ROUTING 5'h02
`define ADDR_CLOCK 5'h03
`define ADDR_CHANSTAT0 5'h04
`define ADDR_CHANSTAT4 5'h08
`define ADDR_STATUS 5'h09

// Reset values
`define RST_CONTROL 8'h03
`define RST_DEEMPH 8'h03
`define RST_ROUTING 8'h00
`define RST_CLOCK 8'h00
`define RST_CHANSTAT 40'h00_0000_0000

// Field positions
`define BIT_SOFT_RESET_N 0
`define BIT_RECOVERY_POWER_N 1
`define BIT_AUTO_DEEMPH 0
`define BIT_DEM_LO 1
`define BIT_DEM_HI 2
`define BIT_RATE_SELECT 3
`define BIT_TRANSMIT_SELECT 4
`define BIT_VALIDITY_CONTROL 5
`define BIT_EXT_SOURCE 2
`define BIT_CLOCK_SPEED 3
`define BIT_CHANNEL_NUMBER 20

// Rate codes
`define RATE_44K1 4'h0
`define RATE_48K 4'h2
`define RATE_32K 4'h3
`define RATE_96K 4'hA

// Filter coefficients, Q1.15: feed-forward b0, b1 and feedback
`define COEF_44K1_B0 16'h36F7
`define COEF_44K1_B1 16'hF85C
`define COEF_44K1_FB 16'h50AE
`define COEF_48K_B0 16'h35DA
`define COEF_48K_B1 16'hF649
`define COEF_48K_FB 16'h53DE
`define COEF_32K_B0 16'h3BBD
`define COEF_32K_B1 16'h0137
`define COEF_32K_FB 16'h430C
`define COEF_96K_B0 16'h2ED9
`define COEF_96K_B1 16'hE94B
`define COEF_96K_FB 16'h67D9

`endif

// file: rtl/biphase_ctl_pkg.sv
package biphase_ctl_pkg;

	typedef enum logic [2:0] {
		DEEMPH_OFF,
		DEEMPH_32K,
		DEEMPH_44K1,
		DEEMPH_48K,
		DEEMPH_96K
	} deemph_mode_t;

	// Status coming from the decoder
	typedef struct packed {
		logic preemphasis_flag;
		logic unlock;
		logic [3:0] detected_rate_code;
		logic validity;
	} rx_status_t;

	// Position of the transmitter in the block
	typedef struct packed {
		logic right;
		logic [7:0] index;
	} tx_slot_t;

	// Transmitter clock choice
	typedef struct packed {
		logic use_external;
		logic ext_from_second;
		logic [9:0] ratio_fs;
		logic [7:0] fs_max_khz;
	} clock_sel_t;

endpackage

// file: rtl/biphase_rx_tx_control.sv
`timescale 1ns/1ps
`include "biphase_ctl_regs.svh"

module biphase_rx_tx_control (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic power_down_pin,
	input wire logic parallel_mode,
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [3:0] biphase_inputs,
	input wire logic int_tx_stream,
	input wire biphase_ctl_pkg::rx_status_t rx_status,
	input wire logic signed [23:0] rx_sample,
	input wire logic rx_sample_valid,
	input wire biphase_ctl_pkg::tx_slot_t tx_slot,
	output logic decoder_input,
	output logic tx_pin,
	output logic validity_out,
	output logic signed [23:0] serial_audio_out,
	output logic serial_audio_valid,
	output logic deemph_active,
	output logic tx_cs_bit,
	output logic tx_user_bit,
	output logic tx_validity_bit,
	output logic recovery_run,
	output biphase_ctl_pkg::clock_sel_t clock_sel
);
	import biphase_ctl_pkg::*;

	logic [1:0] pin_pd_sync;
	logic [1:0] par_sync;
	logic [3:0] rx_meta;
	logic [3:0] rx_pins;
	logic pd;
	logic par;
	logic [7:0] ctrl;
	logic [7:0] deemph_cfg;
	logic [7:0] routing;
	logic [7:0] clock_cfg;
	logic [39:0] chanstat_tx_field;
	logic soft_reset_n;
	logic recovery_power_n;
	logic regs_clear;
	logic access_ok;
	logic auto_active;
	logic [1:0] manual_sel;
	deemph_mode_t deemph_mode;
	deemph_mode_t next_mode;
	logic signed [15:0] coef_b0;
	logic signed [15:0] coef_b1;
	logic signed [15:0] coef_fb;
	logic signed [23:0] x_prev;
	logic signed [23:0] y_prev;
	logic signed [39:0] prod0;
	logic signed [39:0] prod1;
	logic signed [39:0] prod2;
	logic signed [41:0] acc;
	logic next_cs;
	clock_sel_t next_clk;

	// Pin synchronisers
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			pin_pd_sync <= 2'h0;
			par_sync <= 2'h0;
			rx_meta <= 4'h0;
			rx_pins <= 4'h0;
		end
		else if (clk_en)
		begin
			pin_pd_sync <= {pin_pd_sync[0], power_down_pin};
			par_sync <= {par_sync[0], parallel_mode};
			rx_meta <= biphase_inputs;
			rx_pins <= rx_meta;
		end
	end

	// Derived control levels
	assign pd = ~pin_pd_sync[1];
	assign par = par_sync[1];
	assign soft_reset_n = ctrl[`BIT_SOFT_RESET_N];
	assign recovery_power_n = ctrl[`BIT_RECOVERY_POWER_N];
	assign regs_clear = pd | ~soft_reset_n;
	assign access_ok = ~pd & soft_reset_n;

	// Reset and recovery power bits, kept through soft reset
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			ctrl <= `RST_CONTROL;
		else if (clk_en)
		begin
			if (pd)
				ctrl <= `RST_CONTROL;
			else if (reg_wr && reg_addr == `ADDR_CONTROL)
				ctrl <= {6'h00, reg_wdata[1:0]};
		end
	end

	// Configuration registers, cleared by either reset
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			deemph_cfg <= `RST_DEEMPH;
			routing <= `RST_ROUTING;
			clock_cfg <= `RST_CLOCK;
			chanstat_tx_field <= `RST_CHANSTAT;
		end
		else if (clk_en)
		begin
			if (regs_clear)
			begin
				deemph_cfg <= `RST_DEEMPH;
				routing <= `RST_ROUTING;
				clock_cfg <= `RST_CLOCK;
				chanstat_tx_field <= `RST_CHANSTAT;
			end
			else if (reg_wr)
			begin
				if (reg_addr == `ADDR_DEEMPH)
					deemph_cfg <= {4'h0, reg_wdata[3:0]};
				else if (reg_addr == `ADDR_ROUTING)
					routing <= {2'h0, reg_wdata[5:0]};
				else if (reg_addr == `ADDR_CLOCK)
					clock_cfg <= {2'h0, reg_wdata[5:0]};
				else if (reg_addr >= `ADDR_CHANSTAT0 && reg_addr <= `ADDR_CHANSTAT4)
					chanstat_tx_field[8 * (reg_addr - `ADDR_CHANSTAT0) +: 8] <= reg_wdata;
			end
		end
	end

	// Read port, data one cycle after the strobe
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			reg_rdata <= 8'h00;
		else if (clk_en)
		begin
			if (!reg_rd || !access_ok)
				reg_rdata <= 8'h00;
			else if (reg_addr == `ADDR_CONTROL)
				reg_rdata <= ctrl;
			else if (reg_addr == `ADDR_DEEMPH)
				reg_rdata <= deemph_cfg;
			else if (reg_addr == `ADDR_ROUTING)
				reg_rdata <= routing;
			else if (reg_addr == `ADDR_CLOCK)
				reg_rdata <= clock_cfg;
			else if (reg_addr >= `ADDR_CHANSTAT0 && reg_addr <= `ADDR_CHANSTAT4)
				reg_rdata <= chanstat_tx_field[8 * (reg_addr - `ADDR_CHANSTAT0) +: 8];
			else if (reg_addr == `ADDR_STATUS)
				reg_rdata <= {1'b0, deemph_active, rx_status.detected_rate_code,
					rx_status.unlock, rx_status.preemphasis_flag};
			else
				reg_rdata <= 8'h00;
		end
	end

	// Filter mode selection
	assign auto_active = par | deemph_cfg[`BIT_AUTO_DEEMPH];
	assign manual_sel = {deemph_cfg[`BIT_DEM_HI], deemph_cfg[`BIT_DEM_LO]};

	always_comb
	begin
		next_mode = DEEMPH_OFF;
		if (!rx_status.preemphasis_flag)
			next_mode = DEEMPH_OFF;
		else if (auto_active)
		begin
			case (rx_status.detected_rate_code)
				`RATE_44K1: next_mode = DEEMPH_44K1;
				`RATE_48K: next_mode = DEEMPH_48K;
				`RATE_32K: next_mode = DEEMPH_32K;
				`RATE_96K: next_mode = DEEMPH_96K;
				default: next_mode = DEEMPH_OFF;
			endcase
		end
		else if (deemph_cfg[`BIT_RATE_SELECT])
			next_mode = (manual_sel == 2'b10) ? DEEMPH_96K : DEEMPH_OFF;
		else
		begin
			case (manual_sel)
				2'b00: next_mode = DEEMPH_44K1;
				2'b10: next_mode = DEEMPH_48K;
				2'b11: next_mode = DEEMPH_32K;
				default: next_mode = DEEMPH_OFF;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			deemph_mode <= DEEMPH_OFF;
			deemph_active <= 1'b0;
		end
		else if (clk_en)
		begin
			deemph_mode <= next_mode;
			deemph_active <= (next_mode != DEEMPH_OFF);
		end
	end

	// First-order shelving coefficients per rate
	always_comb
	begin
		coef_b0 = 16'sh0000;
		coef_b1 = 16'sh0000;
		coef_fb = 16'sh0000;
		case (deemph_mode)
			DEEMPH_44K1:
				{coef_b0, coef_b1, coef_fb} = {`COEF_44K1_B0, `COEF_44K1_B1, `COEF_44K1_FB};
			DEEMPH_48K:
				{coef_b0, coef_b1, coef_fb} = {`COEF_48K_B0, `COEF_48K_B1, `COEF_48K_FB};
			DEEMPH_32K:
				{coef_b0, coef_b1, coef_fb} = {`COEF_32K_B0, `COEF_32K_B1, `COEF_32K_FB};
			DEEMPH_96K:
				{coef_b0, coef_b1, coef_fb} = {`COEF_96K_B0, `COEF_96K_B1, `COEF_96K_FB};
			default: coef_b0 = 16'sh0000;
		endcase
	end

	// IIR arithmetic, unity DC gain so no saturation needed
	assign prod0 = rx_sample * coef_b0;
	assign prod1 = x_prev * coef_b1;
	assign prod2 = y_prev * coef_fb;
	assign acc = 42'(prod0) + 42'(prod1) + 42'(prod2);

	// Filter state and audio output
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			x_prev <= 24'sh00_0000;
			y_prev <= 24'sh00_0000;
			serial_audio_out <= 24'sh00_0000;
			serial_audio_valid <= 1'b0;
		end
		else if (clk_en)
		begin
			serial_audio_valid <= 1'b0;
			if (regs_clear)
			begin
				x_prev <= 24'sh00_0000;
				y_prev <= 24'sh00_0000;
				serial_audio_out <= 24'sh00_0000;
			end
			else if (rx_sample_valid)
			begin
				serial_audio_valid <= 1'b1;
				x_prev <= rx_sample;
				if (deemph_mode == DEEMPH_OFF)
				begin
					y_prev <= rx_sample;
					serial_audio_out <= rx_sample;
				end
				else
				begin
					y_prev <= acc[38:15];
					serial_audio_out <= acc[38:15];
				end
			end
		end
	end

	// Routing of receiver inputs and biphase output
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			decoder_input <= 1'b0;
			tx_pin <= 1'b0;
			validity_out <= 1'b0;
			recovery_run <= 1'b0;
		end
		else if (clk_en)
		begin
			decoder_input <= rx_pins[routing[1:0]];
			if (routing[`BIT_TRANSMIT_SELECT])
				tx_pin <= int_tx_stream;
			else
				tx_pin <= rx_pins[routing[3:2]];
			validity_out <= rx_status.validity;
			recovery_run <= ~pd & recovery_power_n;
		end
	end

	// Channel status bit for the current transmit slot
	always_comb
	begin
		next_cs = 1'b0;
		if (tx_slot.index < 8'd40)
			next_cs = chanstat_tx_field[tx_slot.index[5:0]];
		if (!chanstat_tx_field[0] && tx_slot.index >= 8'd20 && tx_slot.index <= 8'd23)
		begin
			next_cs = 1'b0;
			if (chanstat_tx_field[`BIT_CHANNEL_NUMBER])
				next_cs = tx_slot.right ? (tx_slot.index == 8'd21)
					: (tx_slot.index == 8'd20);
		end
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			tx_cs_bit <= 1'b0;
			tx_user_bit <= 1'b0;
			tx_validity_bit <= 1'b0;
		end
		else if (clk_en)
		begin
			tx_cs_bit <= next_cs;
			tx_user_bit <= 1'b0;
			tx_validity_bit <= routing[`BIT_VALIDITY_CONTROL];
		end
	end

	// Transmitter clock source and ratio
	always_comb
	begin
		next_clk.ext_from_second = clock_cfg[`BIT_EXT_SOURCE];
		case (clock_cfg[1:0])
			2'b00: next_clk.use_external = 1'b0;
			2'b10: next_clk.use_external = rx_status.unlock;
			default: next_clk.use_external = 1'b1;
		endcase
		case ({clock_cfg[`BIT_CLOCK_SPEED], clock_cfg[5:4]})
			3'b010: {next_clk.ratio_fs, next_clk.fs_max_khz} = {10'd512, 8'd48};
			3'b011: {next_clk.ratio_fs, next_clk.fs_max_khz} = {10'd128, 8'd192};
			3'b100: {next_clk.ratio_fs, next_clk.fs_max_khz} = {10'd384, 8'd48};
			3'b101: {next_clk.ratio_fs, next_clk.fs_max_khz} = {10'd384, 8'd48};
			3'b110: {next_clk.ratio_fs, next_clk.fs_max_khz} = {10'd768, 8'd32};
			3'b111: {next_clk.ratio_fs, next_clk.fs_max_khz} = {10'd192, 8'd96};
			default: {next_clk.ratio_fs, next_clk.fs_max_khz} = {10'd256, 8'd96};
		endcase
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			clock_sel <= '0;
		else if (clk_en)
			clock_sel <= next_clk;
	end

	// Checks
	AST_AUTO_48K: assert property (@(posedge sys_clk) disable iff (reset)
		clk_en && auto_active && rx_status.preemphasis_flag
		&& rx_status.detected_rate_code == 4'h2 |=> deemph_mode == DEEMPH_48K)
		else $error("auto mode did not pick 48k");
	AST_AUTO_OFF: assert property (@(posedge sys_clk) disable iff (reset)
		clk_en && !rx_status.preemphasis_flag |=> !deemph_active)
		else $error("filter active without pre-emphasis");
	AST_MANUAL_96K: assert property (@(posedge sys_clk) disable iff (reset)
		clk_en && !auto_active && rx_status.preemphasis_flag
		&& deemph_cfg[3] && manual_sel != 2'b10 |=> deemph_mode == DEEMPH_OFF)
		else $error("manual 96k select wrong");
	AST_BYPASS: assert property (@(posedge sys_clk) disable iff (reset)
		clk_en && !regs_clear && rx_sample_valid && deemph_mode == DEEMPH_OFF
		|=> serial_audio_out == $past(rx_sample) && serial_audio_valid)
		else $error("bypass altered sample");
	AST_PD_REFUSE: assert property (@(posedge sys_clk) disable iff (reset)
		clk_en && pd |=> reg_rdata == 8'h00 && ctrl == 8'h03)
		else $error("power-down did not refuse access");
	AST_SOFT_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
		clk_en && !pd && !soft_reset_n |=> routing == 8'h00 && serial_audio_out == 0)
		else $error("soft reset let write through");
	AST_TX_INTERNAL: assert property (@(posedge sys_clk) disable iff (reset)
		clk_en && routing[4] |=> tx_pin == $past(int_tx_stream))
		else $error("transmitter not on output pin");
	AST_CHAN_NUM: assert property (@(posedge sys_clk) disable iff (reset)
		clk_en && !chanstat_tx_field[0] && chanstat_tx_field[20] && tx_slot.right
		&& tx_slot.index == 8'd21 |=> tx_cs_bit)
		else $error("right channel number bit missing");
	AST_CLK_MODE2: assert property (@(posedge sys_clk) disable iff (reset)
		clk_en && clock_cfg[1:0] == 2'b10 |=> clock_sel.use_external == $past(rx_status.unlock))
		else $error("mode 2 clock choice wrong");
endmodule

// file: bench/biphase_partner.sv
`timescale 1ns/1ps
module biphase_partner (
	input wire logic sys_clk,
	input wire logic [3:0] line_level,
	input wire biphase_ctl_pkg::rx_status_t status_in,
	output logic [3:0] biphase_inputs,
	output biphase_ctl_pkg::rx_status_t rx_status,
	output logic signed [23:0] rx_sample,
	output logic rx_sample_valid,
	output logic signed [23:0] sent
);
	import biphase_ctl_pkg::*;
	logic [2:0] phase;
	// Known start so the first samples are defined
	initial
	begin
		phase = 3'h0;
		rx_sample_valid = 1'h0;
		sent = 24'h00_0000;
		rx_sample = 24'h00_0000;
	end
	// Receiver lines and decoder status follow the scenario
	assign biphase_inputs = line_level;
	assign rx_status = status_in;
	// One recovered sample every eight cycles, scrambled data between
	always @(posedge sys_clk)
	begin
		phase <= phase + 3'h1;
		rx_sample_valid <= (phase == 3'h7);
		if (phase == 3'h7)
		begin
			sent <= sent + 24'h01_2345;
			rx_sample <= sent + 24'h01_2345;
		end
		else
			rx_sample <= ~rx_sample;
	end
endmodule

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
	import biphase_ctl_pkg::*;
	logic sys_clk, reset, power_down_pin, parallel_mode, reg_wr, reg_rd, int_tx_stream;
	logic [4:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic [3:0] line_level, biphase_inputs;
	rx_status_t status_in, rx_status;
	tx_slot_t tx_slot;
	clock_sel_t clock_sel;
	logic signed [23:0] rx_sample, sent, serial_audio_out;
	logic rx_sample_valid, decoder_input, tx_pin, validity_out, serial_audio_valid;
	logic deemph_active, tx_cs_bit, tx_user_bit, tx_validity_bit, recovery_run;
	logic [9:0] ratio_tbl [8] = '{10'h100, 10'h100, 10'h200, 10'h080,
		10'h180, 10'h180, 10'h300, 10'h0C0};
	logic [7:0] fs_tbl [8] = '{8'h60, 8'h60, 8'h30, 8'hC0, 8'h30, 8'h30, 8'h20, 8'h60};
	int miscompares = 0;
	int n_tests = 0;
	int cycles = 0;

	biphase_rx_tx_control i_biphase_rx_tx_control (.sys_clk(sys_clk), .reset(reset),
		.clk_en(1'h1), .power_down_pin(power_down_pin), .parallel_mode(parallel_mode),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .biphase_inputs(biphase_inputs), .int_tx_stream(int_tx_stream),
		.rx_status(rx_status), .rx_sample(rx_sample), .rx_sample_valid(rx_sample_valid),
		.tx_slot(tx_slot), .decoder_input(decoder_input), .tx_pin(tx_pin),
		.validity_out(validity_out), .serial_audio_out(serial_audio_out),
		.serial_audio_valid(serial_audio_valid), .deemph_active(deemph_active),
		.tx_cs_bit(tx_cs_bit), .tx_user_bit(tx_user_bit),
		.tx_validity_bit(tx_validity_bit), .recovery_run(recovery_run),
		.clock_sel(clock_sel));
	biphase_partner i_biphase_partner (.sys_clk(sys_clk), .line_level(line_level),
		.status_in(status_in), .biphase_inputs(biphase_inputs), .rx_status(rx_status),
		.rx_sample(rx_sample), .rx_sample_valid(rx_sample_valid), .sent(sent));

	// Free-running 10 MHz clock
	initial
	begin
		sys_clk = 1'h0;
		forever #50 sys_clk = ~sys_clk;
	end

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Hang guard
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			summarize();
		end
	end

	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Register bus cycles: one strobe cycle, then one idle edge
	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'h1;
		@(posedge sys_clk);
		reg_wr <= 1'h0;
		@(posedge sys_clk);
	endtask
	task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
		logic [7:0] v;
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge sys_clk);
		reg_rd <= 1'h0;
		#1 v = reg_rdata;
		check({16'h0000, v}, {16'h0000, e});
		@(posedge sys_clk);
	endtask
	task automatic settle;
		repeat (4) @(posedge sys_clk);
	endtask

	task automatic t_defaults;
		rdchk(5'h00, 8'h03);
		rdchk(5'h01, 8'h03);
		rdchk(5'h02, 8'h00);
		rdchk(5'h03, 8'h00);
		rdchk(5'h09, 8'h00);
		rdchk(5'h1F, 8'h00);
	endtask

	task automatic t_auto;
		for (int c = 0; c < 16; c++)
		begin
			status_in <= '{1'h1, 1'h0, 4'(c), 1'h0};
			settle();
			check({23'h0, deemph_active}, {23'h0, c == 0 || c == 2 || c == 3 || c == 10});
			rdchk(5'h09, {1'h0, c == 0 || c == 2 || c == 3 || c == 10, 4'(c), 2'h1});
		end
		status_in <= '{1'h0, 1'h0, 4'h0, 1'h0};
		settle();
		check({23'h0, deemph_active}, 24'h00_0000);
	endtask

	task automatic t_manual;
		status_in <= '{1'h1, 1'h0, 4'h0, 1'h0};
		for (int v = 0; v < 8; v++)
		begin
			wr(5'h01, 8'(v << 1));
			settle();
			check({23'h0, deemph_active}, {23'h0, 1'(8'h4D >> v)});
		end
		wr(5'h01, 8'h02);
		parallel_mode <= 1'h1;
		settle();
		check({23'h0, deemph_active}, 24'h00_0001);
		parallel_mode <= 1'h0;
		settle();
		check({23'h0, deemph_active}, 24'h00_0000);
	endtask

	task automatic t_bypass;
		for (int i = 0; i < 20 && serial_audio_valid !== 1'h1; i++)
			@(posedge sys_clk);
		check({23'h0, serial_audio_valid}, 24'h00_0001);
		check(serial_audio_out, sent);
	endtask

	task automatic t_routing;
		for (int s = 0; s < 4; s++)
		begin
			line_level <= 4'h1 << s;
			wr(5'h02, 8'(s | (((s + 1) % 4) << 2)));
			settle();
			check({23'h0, decoder_input}, 24'h00_0001);
			check({23'h0, tx_pin}, 24'h00_0000);
		end
		status_in <= '{1'h0, 1'h0, 4'h0, 1'h1};
		wr(5'h02, 8'h10);
		int_tx_stream <= 1'h1;
		settle();
		check({23'h0, tx_pin}, 24'h00_0001);
		check({23'h0, validity_out}, 24'h00_0001);
	endtask

	task automatic slot(input logic r, input logic [7:0] i, input logic e);
		tx_slot <= '{r, i};
		settle();
		check({21'h0, tx_cs_bit, tx_user_bit, tx_validity_bit}, {21'h0, e, 2'h1});
	endtask
	task automatic t_tx;
		wr(5'h02, 8'h30);
		wr(5'h04, 8'h20);
		wr(5'h06, 8'h10);
		slot(1'h0, 8'h05, 1'h1);
		slot(1'h0, 8'h04, 1'h0);
		slot(1'h0, 8'h14, 1'h1);
		slot(1'h0, 8'h15, 1'h0);
		slot(1'h1, 8'h14, 1'h0);
		slot(1'h1, 8'h15, 1'h1);
		slot(1'h1, 8'h16, 1'h0);
		wr(5'h06, 8'h00);
		slot(1'h0, 8'h14, 1'h0);
		wr(5'h04, 8'h01);
		wr(5'h06, 8'h20);
		slot(1'h0, 8'h15, 1'h1);
	endtask

	task automatic t_clock;
		logic [1:0] m;
		for (int v = 0; v < 64; v++)
		begin
			m = 2'(v);
			status_in <= '{1'h0, v[4] ^ v[3], 4'h0, 1'h0};
			wr(5'h03, 8'(v));
			settle();
			check({4'h0, clock_sel}, {4'h0, m[0] | (m[1] & (v[4] ^ v[3])), v[2],
				ratio_tbl[v[5:3] >> 0 & 3'h7 ? {v[3], v[5:4]} : 3'h0],
				fs_tbl[{v[3], v[5:4]}]});
		end
	endtask

	task automatic t_soft;
		wr(5'h02, 8'h05);
		wr(5'h00, 8'h02);
		repeat (10) @(posedge sys_clk);
		check(serial_audio_out, 24'h00_0000);
		rdchk(5'h00, 8'h00);
		wr(5'h02, 8'h0A);
		wr(5'h00, 8'h03);
		rdchk(5'h02, 8'h00);
		rdchk(5'h00, 8'h03);
	endtask

	task automatic t_recovery;
		wr(5'h02, 8'h05);
		wr(5'h00, 8'h01);
		settle();
		check({23'h0, recovery_run}, 24'h00_0000);
		wr(5'h02, 8'h06);
		rdchk(5'h02, 8'h06);
		wr(5'h00, 8'h03);
	endtask

	task automatic t_powerdown;
		power_down_pin <= 1'h0;
		settle();
		rdchk(5'h02, 8'h00);
		check({23'h0, recovery_run}, 24'h00_0000);
		wr(5'h02, 8'h05);
		power_down_pin <= 1'h1;
		settle();
		check({23'h0, recovery_run}, 24'h00_0001);
		rdchk(5'h02, 8'h00);
		rdchk(5'h00, 8'h03);
	endtask

	// Main sequence; the power-down pin is pulsed low with the reset
	initial
	begin
		reset = 1'h1;
		power_down_pin = 1'h0;
		parallel_mode = 1'h0;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		reg_addr = 5'h00;
		reg_wdata = 8'h00;
		int_tx_stream = 1'h0;
		line_level = 4'h0;
		status_in = '{1'h0, 1'h0, 4'h0, 1'h0};
		tx_slot = '{1'h0, 8'h00};
		repeat (4) @(posedge sys_clk);
		reset <= 1'h0;
		power_down_pin <= 1'h1;
		repeat (4) @(posedge sys_clk);
		t_defaults();
		t_auto();
		t_bypass();
		t_manual();
		t_routing();
		t_tx();
		t_clock();
		t_soft();
		t_recovery();
		t_powerdown();
		summarize();
	end
endmodule
